// [hw/nrcs_defines.svh]
`ifndef NRCS_DEFINES_SVH
`define NRCS_DEFINES_SVH

// ************************************************
// Clock and busy times
// ************************************************
`define NRCS_CLK_PERIOD_NS 5
`define NRCS_PAGE_LOAD_NS 20000
`define NRCS_ECC_PAGE_LOAD_NS 20400
`define NRCS_CACHE_BUSY_NS 3000
`define NRCS_PCACHE_BUSY_NS 3000
`define NRCS_LAST_PROG_NS 20000
`define NRCS_CYC(ns) (((ns) + `NRCS_CLK_PERIOD_NS - 1) / `NRCS_CLK_PERIOD_NS)
`define NRCS_PAGE_LOAD_CYC 12'(`NRCS_CYC(`NRCS_PAGE_LOAD_NS))
`define NRCS_ECC_PAGE_LOAD_CYC 12'(`NRCS_CYC(`NRCS_ECC_PAGE_LOAD_NS))
`define NRCS_CACHE_BUSY_CYC 12'(`NRCS_CYC(`NRCS_CACHE_BUSY_NS))
`define NRCS_PCACHE_BUSY_CYC 12'(`NRCS_CYC(`NRCS_PCACHE_BUSY_NS))
`define NRCS_LAST_PROG_CYC 12'(`NRCS_CYC(`NRCS_LAST_PROG_NS))

// ************************************************
// Command codes
// ************************************************
`define NRCS_CMD_READ_MODE 8'h00
`define NRCS_CMD_PAGE_CONF 8'h30
`define NRCS_CMD_CACHE_SEQ 8'h31
`define NRCS_CMD_CACHE_LAST 8'h3f
`define NRCS_CMD_STATUS 8'h70
`define NRCS_CMD_STATUS_ENH 8'h78
`define NRCS_CMD_RESET 8'hff
`define NRCS_CMD_RND_READ 8'h05
`define NRCS_CMD_RND_CONF 8'he0
`define NRCS_CMD_PROG 8'h80
`define NRCS_CMD_PROG_CONF 8'h10
`define NRCS_CMD_PCACHE_CONF 8'h15
`define NRCS_CMD_DATA_IN 8'h85

// ************************************************
// Address and status layout
// ************************************************
`define NRCS_ADDR_CYCLES 3'h5
`define NRCS_COL_CYCLES 3'h2
`define NRCS_PAGE_BYTES 12'h880
`define NRCS_ST_RDY_BIT 6
`define NRCS_ST_ARRAY_READY_FLAG_BIT 5
`define NRCS_ST_FAIL_BIT 0

`endif

// [hw/nrcs_fifo.sv]
`timescale 1ns/1ps

module nrcs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n_sync,
  nrcs_stream_if.fifo_side sif
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;

  wire full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  wire empty = (wptr == rptr);
  wire do_wr = sif.wr_valid && !full && !sif.clear;
  wire do_rd = sif.rd_ready && !empty && !sif.clear;

  assign sif.wr_ready = !full;
  assign sif.rd_valid = !empty;
  assign sif.rd_data = mem[rptr[AW-1:0]];

  // ************************************************
  // Pointers
  // ************************************************
  always_ff @(posedge ref_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      wptr <= '0;
      rptr <= '0;
    end
    else if (sif.clear)
    begin
      wptr <= '0;
      rptr <= '0;
    end
    else
    begin
      if (do_wr)
        wptr <= wptr + 1'b1;
      if (do_rd)
        rptr <= rptr + 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (do_wr)
      mem[wptr[AW-1:0]] <= sif.wr_data;
  end
endmodule

// [hw/nrcs_pkg.sv]
package nrcs_pkg;

  typedef enum logic [2:0] {
    ST_READY = 3'b000,
    ST_PAGE_LOAD = 3'b001,
    ST_CACHE_BUSY = 3'b010,
    ST_CACHE_ACTIVE = 3'b011,
    ST_LAST_BUSY = 3'b100,
    ST_PCACHE_BUSY = 3'b101,
    ST_PCACHE_ACTIVE = 3'b110,
    ST_PROG_BUSY = 3'b111
  } nrcs_state_type;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_READ = 2'b01,
    PH_RND = 2'b10,
    PH_PROG = 2'b11
  } nrcs_phase_type;

endpackage

// [hw/nrcs_seq.sv]
// Function
// - Read-mode after status polling switches output from status back to data
// - Read-mode and cache reads taken when ready or during cache read
// - Page read is 00h, full address, 30h; taken only when fully ready
// - After 30h both ready flags stay low for page load time
// - Random data read pair changes output column during data output
// - 31h: busy pin low for cache busy time, then lun ready only, column 0
// - Sequential cache read after last page continues in next block
// - Random cache read ignores column, loads addressed block and page
// - 3Fh: busy for cache busy time, then fully ready, column 0
// - Program-cache confirm: busy, then lun ready with array busy
// - During program busy times only status and reset are taken
// - During program-cache activity only program-related, status, reset taken
// - During cache busy time only status and reset are taken
// - During active cache read only read-related, status, reset taken
`timescale 1ns/1ps
`include "nrcs_defines.svh"

module nrcs_seq (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cmd_stb,
  input wire logic addr_stb,
  input wire logic [7:0] bus_byte,
  input wire logic ecc_enable,
  input wire logic op_fail_flag,
  input wire logic [7:0] cache_rd_data,
  input wire logic dout_ready,
  output logic lun_ready_flag,
  output logic array_ready_flag,
  output logic target_busy_n,
  output logic out_status_mode,
  output logic [7:0] status_byte,
  output logic [11:0] cache_rd_addr,
  output logic [16:0] load_row,
  output logic array_load,
  output logic cache_copy,
  output logic prog_copy,
  output logic dout_valid,
  output logic [7:0] dout_data
);
  logic rst_q1;
  logic rst_q;
  nrcs_pkg::nrcs_state_type state;
  nrcs_pkg::nrcs_state_type next_state;
  nrcs_pkg::nrcs_phase_type phase;
  logic [11:0] tmr;
  logic [11:0] next_tmr;
  logic [2:0] addr_cnt;
  logic [11:0] col_addr;
  logic [16:0] row_addr;
  logic [7:0] next_status;

  nrcs_stream_if #(.WIDTH(8)) sif ();

  // ************************************************
  // Decoding
  // ************************************************
  function automatic logic lun_rdy(input nrcs_pkg::nrcs_state_type st);
    lun_rdy = (st == nrcs_pkg::ST_READY) || (st == nrcs_pkg::ST_CACHE_ACTIVE)
      || (st == nrcs_pkg::ST_PCACHE_ACTIVE);
  endfunction

  function automatic logic cmd_ok(input nrcs_pkg::nrcs_state_type st,
                                  input logic [7:0] c);
    logic base;
    base = (c == `NRCS_CMD_STATUS) || (c == `NRCS_CMD_STATUS_ENH)
      || (c == `NRCS_CMD_RESET);
    case (st)
      nrcs_pkg::ST_READY: cmd_ok = 1'b1;
      nrcs_pkg::ST_CACHE_ACTIVE: cmd_ok = base || (c == `NRCS_CMD_READ_MODE)
        || (c == `NRCS_CMD_CACHE_SEQ) || (c == `NRCS_CMD_CACHE_LAST)
        || (c == `NRCS_CMD_RND_READ) || (c == `NRCS_CMD_RND_CONF);
      nrcs_pkg::ST_PCACHE_ACTIVE: cmd_ok = base || (c == `NRCS_CMD_PROG)
        || (c == `NRCS_CMD_PROG_CONF) || (c == `NRCS_CMD_PCACHE_CONF)
        || (c == `NRCS_CMD_DATA_IN);
      default: cmd_ok = base;
    endcase
  endfunction

  wire cmd_take = cmd_stb && cmd_ok(state, bus_byte);
  wire addr_full = (addr_cnt == `NRCS_ADDR_CYCLES);
  wire read_ctx = (state == nrcs_pkg::ST_READY) || (state == nrcs_pkg::ST_CACHE_ACTIVE);
  wire take_read = cmd_take && (bus_byte == `NRCS_CMD_READ_MODE);
  wire take_page = cmd_take && (bus_byte == `NRCS_CMD_PAGE_CONF) && (phase == nrcs_pkg::PH_READ)
    && addr_full && (state == nrcs_pkg::ST_READY);
  wire take_rand = cmd_take && (bus_byte == `NRCS_CMD_CACHE_SEQ)
    && (phase == nrcs_pkg::PH_READ) && addr_full && read_ctx;
  wire take_seq = cmd_take && (bus_byte == `NRCS_CMD_CACHE_SEQ)
    && ((phase != nrcs_pkg::PH_READ) || (addr_cnt == 3'h0)) && read_ctx;
  wire take_last = cmd_take && (bus_byte == `NRCS_CMD_CACHE_LAST) && read_ctx;
  wire take_rnd = cmd_take && (bus_byte == `NRCS_CMD_RND_READ);
  wire take_rnd_conf = cmd_take && (bus_byte == `NRCS_CMD_RND_CONF)
    && (phase == nrcs_pkg::PH_RND) && (addr_cnt == `NRCS_COL_CYCLES) && !out_status_mode;
  wire take_prog = cmd_take && (bus_byte == `NRCS_CMD_PROG);
  wire take_din = cmd_take && (bus_byte == `NRCS_CMD_DATA_IN) && (phase == nrcs_pkg::PH_PROG);
  wire take_p10 = cmd_take && (bus_byte == `NRCS_CMD_PROG_CONF)
    && (phase == nrcs_pkg::PH_PROG) && addr_full;
  wire take_p15 = cmd_take && (bus_byte == `NRCS_CMD_PCACHE_CONF)
    && (phase == nrcs_pkg::PH_PROG) && addr_full;
  wire take_status = cmd_take
    && ((bus_byte == `NRCS_CMD_STATUS) || (bus_byte == `NRCS_CMD_STATUS_ENH));
  wire take_reset = cmd_take && (bus_byte == `NRCS_CMD_RESET);
  wire take_addr = addr_stb && (phase != nrcs_pkg::PH_IDLE) && !addr_full;
  wire confirm = take_page || take_rand || take_seq || take_last || take_p10 || take_p15;
  wire flush = take_page || take_rand || take_seq || take_last || take_rnd_conf
    || take_reset || take_status;
  wire timeout = (tmr == 12'h001);
  wire push = !out_status_mode && read_ctx && (cache_rd_addr < `NRCS_PAGE_BYTES)
    && sif.wr_ready && !flush;

  // ************************************************
  // Busy sequencing
  // ************************************************
  always_comb
  begin
    next_state = state;
    next_tmr = (tmr != 12'h000) ? tmr - 12'h001 : tmr;
    if (take_reset)
    begin
      next_state = nrcs_pkg::ST_READY;
      next_tmr = 12'h000;
    end
    else if (take_page)
    begin
      next_state = nrcs_pkg::ST_PAGE_LOAD;
      next_tmr = ecc_enable ? `NRCS_ECC_PAGE_LOAD_CYC : `NRCS_PAGE_LOAD_CYC;
    end
    else if (take_seq || take_rand)
    begin
      next_state = nrcs_pkg::ST_CACHE_BUSY;
      next_tmr = `NRCS_CACHE_BUSY_CYC;
    end
    else if (take_last)
    begin
      next_state = nrcs_pkg::ST_LAST_BUSY;
      next_tmr = `NRCS_CACHE_BUSY_CYC;
    end
    else if (take_p15)
    begin
      next_state = nrcs_pkg::ST_PCACHE_BUSY;
      next_tmr = `NRCS_PCACHE_BUSY_CYC;
    end
    else if (take_p10)
    begin
      next_state = nrcs_pkg::ST_PROG_BUSY;
      next_tmr = `NRCS_LAST_PROG_CYC;
    end
    else if (timeout)
    begin
      unique case (state)
        nrcs_pkg::ST_CACHE_BUSY: next_state = nrcs_pkg::ST_CACHE_ACTIVE;
        nrcs_pkg::ST_PCACHE_BUSY:
        begin
          next_state = nrcs_pkg::ST_PCACHE_ACTIVE;
          next_tmr = `NRCS_LAST_PROG_CYC;
        end
        nrcs_pkg::ST_READY: next_state = nrcs_pkg::ST_READY;
        nrcs_pkg::ST_CACHE_ACTIVE: next_state = nrcs_pkg::ST_CACHE_ACTIVE;
        nrcs_pkg::ST_PAGE_LOAD,
        nrcs_pkg::ST_LAST_BUSY,
        nrcs_pkg::ST_PCACHE_ACTIVE,
        nrcs_pkg::ST_PROG_BUSY: next_state = nrcs_pkg::ST_READY;
      endcase
    end
  end

  always_comb
  begin
    next_status = 8'h00;
    next_status[`NRCS_ST_RDY_BIT] = lun_rdy(next_state);
    next_status[`NRCS_ST_ARRAY_READY_FLAG_BIT] = (next_state == nrcs_pkg::ST_READY);
    next_status[`NRCS_ST_FAIL_BIT] = op_fail_flag;
  end

  // ************************************************
  // Reset release
  // ************************************************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_q1 <= 1'b0;
      rst_q <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_q <= rst_q1;
    end
  end

  // ************************************************
  // State, flags and address capture
  // ************************************************
  always_ff @(posedge ref_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      state <= nrcs_pkg::ST_READY;
      tmr <= 12'h000;
      lun_ready_flag <= 1'b1;
      array_ready_flag <= 1'b1;
      target_busy_n <= 1'b1;
      status_byte <= 8'h00;
      load_row <= 17'h00000;
      array_load <= 1'b0;
      cache_copy <= 1'b0;
      prog_copy <= 1'b0;
    end
    else
    begin
      state <= next_state;
      tmr <= next_tmr;
      lun_ready_flag <= lun_rdy(next_state);
      array_ready_flag <= (next_state == nrcs_pkg::ST_READY);
      target_busy_n <= lun_rdy(next_state);
      status_byte <= next_status;
      array_load <= take_page || take_seq || take_rand;
      cache_copy <= take_seq || take_rand || take_last;
      prog_copy <= take_p10 || take_p15;
      if (take_page || take_rand)
        load_row <= row_addr;
      else if (take_seq)
        load_row <= load_row + 17'h00001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      phase <= nrcs_pkg::PH_IDLE;
      addr_cnt <= 3'h0;
      col_addr <= 12'h000;
      row_addr <= 17'h00000;
    end
    else
    begin
      if (take_read)
        phase <= nrcs_pkg::PH_READ;
      else if (take_rnd)
        phase <= nrcs_pkg::PH_RND;
      else if (take_prog)
        phase <= nrcs_pkg::PH_PROG;
      else if (confirm || take_rnd_conf || take_reset)
        phase <= nrcs_pkg::PH_IDLE;
      if (take_read || take_rnd || take_prog || take_din)
        addr_cnt <= 3'h0;
      else if (take_addr)
        addr_cnt <= addr_cnt + 3'h1;
      if (take_addr)
      begin
        unique case (addr_cnt)
          3'h0: col_addr[7:0] <= bus_byte;
          3'h1: col_addr[11:8] <= bus_byte[3:0];
          3'h2: row_addr[7:0] <= bus_byte;
          3'h3: row_addr[15:8] <= bus_byte;
          3'h4: row_addr[16] <= bus_byte[0];
          default: row_addr <= row_addr;
        endcase
      end
    end
  end

  // ************************************************
  // Output column and data stream
  // ************************************************
  assign sif.wr_valid = push;
  assign sif.wr_data = cache_rd_data;
  assign sif.clear = flush;
  assign sif.rd_ready = !dout_valid || dout_ready;

  always_ff @(posedge ref_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      out_status_mode <= 1'b1;
      cache_rd_addr <= 12'h000;
      dout_valid <= 1'b0;
      dout_data <= 8'h00;
    end
    else
    begin
      if (take_status || take_reset)
        out_status_mode <= 1'b1;
      else if (take_read)
        out_status_mode <= 1'b0;
      if (take_page || take_rnd_conf)
        cache_rd_addr <= col_addr;
      else if (take_seq || take_rand || take_last)
        cache_rd_addr <= 12'h000;
      else if (push)
        cache_rd_addr <= cache_rd_addr + 12'h001;
      if (flush)
        dout_valid <= 1'b0;
      else if (sif.rd_ready)
      begin
        dout_valid <= sif.rd_valid;
        dout_data <= sif.rd_data;
      end
    end
  end

  nrcs_fifo #(
    .WIDTH(8),
    .DEPTH(8)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst_n_sync(rst_q),
    .sif(sif)
  );

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_q);

  a_page_load_busy: assert property (take_page |=> (!lun_ready_flag && !array_ready_flag)[*8])
    else $error("Flags not low after page confirm");
  a_seq_busy_pin: assert property (take_seq |=> !target_busy_n && !array_ready_flag
    && cache_rd_addr == 12'h000)
    else $error("Sequential cache read not busy at column zero");
  a_cache_end: assert property (state == nrcs_pkg::ST_CACHE_BUSY && timeout
    && !take_reset |=> lun_ready_flag && !array_ready_flag && target_busy_n)
    else $error("Cache busy end flags wrong");
  a_last_ready: assert property (state == nrcs_pkg::ST_LAST_BUSY && timeout
    |=> lun_ready_flag && array_ready_flag)
    else $error("Last cache read did not return ready");
  a_block_wrap: assert property (take_seq && load_row[5:0] == 6'h3f
    |=> load_row[5:0] == 6'h00 && load_row[16:6] == $past(load_row[16:6]) + 11'h001)
    else $error("Block wrap wrong");
  a_read_mode_data: assert property (take_read |=> !out_status_mode)
    else $error("Read mode did not select data output");
  a_rnd_column: assert property (take_rnd_conf |=> cache_rd_addr == $past(col_addr))
    else $error("Random read column not applied");
  a_busy_ignore: assert property (cmd_stb && !cmd_ok(state, bus_byte) && !timeout && !push
    |=> $stable(state) && $stable(phase) && $stable(cache_rd_addr))
    else $error("Invalid command changed state");
  a_pcache_active: assert property (state == nrcs_pkg::ST_PCACHE_BUSY && timeout
    && !take_reset |=> lun_ready_flag && !array_ready_flag)
    else $error("Program cache busy end flags wrong");
  a_busy_status_only: assert property (!lun_ready_flag && cmd_stb
    && bus_byte == `NRCS_CMD_READ_MODE |=> $stable(out_status_mode))
    else $error("Read mode taken while busy");
endmodule

// [hw/nrcs_stream_if.sv]
`timescale 1ns/1ps

interface nrcs_stream_if #(
  parameter int WIDTH = 8
) ();
  logic wr_valid;
  logic wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [WIDTH-1:0] rd_data;
  logic clear;

  modport fifo_side (
    input wr_valid,
    input wr_data,
    input rd_ready,
    input clear,
    output wr_ready,
    output rd_valid,
    output rd_data
  );

  modport user_side (
    output wr_valid,
    output wr_data,
    output rd_ready,
    output clear,
    input wr_ready,
    input rd_valid,
    input rd_data
  );
endinterface

// [tb/nrcs_host_model.sv]
`timescale 1ns/1ps
`include "nrcs_defines.svh"

// ************************************************
// Cache array and output sink of the far side
// ************************************************
module nrcs_host_model (
  input wire logic ref_clk,
  input wire logic stall_en,
  input wire logic [11:0] cache_rd_addr,
  output logic [7:0] cache_rd_data,
  input wire logic dout_valid,
  output logic dout_ready
);
  logic [3:0] tick = 4'h0;
  wire in_page = cache_rd_addr < `NRCS_PAGE_BYTES;
  wire [7:0] pattern = cache_rd_addr[7:0] ^ {cache_rd_addr[11:8], 4'ha};
  // Off the page the lines show no stale byte
  assign cache_rd_data = in_page ? pattern : ~pattern;
  // Sink stalls in a regular pattern: four cycles ready, four stalled
  always @(posedge ref_clk)
  begin
    tick <= tick + 4'h3;
  end
  assign dout_ready = stall_en ? (tick[0] ^ tick[2]) : 1'b1;
endmodule

// [tb/test_nand_read_cache_cmd_seq.sv]
`timescale 1ns/1ps
`include "nrcs_defines.svh"

module test_nand_read_cache_cmd_seq;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_stb = 1'b0;
  logic addr_stb = 1'b0;
  logic [7:0] bus_byte = 8'h00;
  logic ecc_enable = 1'b0;
  logic op_fail_flag = 1'b0;
  logic stall_en = 1'b1;
  wire [7:0] cache_rd_data;
  wire dout_ready;
  wire lun_ready_flag, array_ready_flag, target_busy_n, out_status_mode;
  wire [7:0] status_byte;
  wire [11:0] cache_rd_addr;
  wire [16:0] load_row;
  wire array_load, cache_copy, prog_copy, dout_valid;
  wire [7:0] dout_data;
  int n_fail = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'he237;
  logic [7:0] got_q[$];
  logic [11:0] col;
  logic [16:0] row;

  always #2.5 ref_clk = ~ref_clk;

  nrcs_seq i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_stb(cmd_stb), .addr_stb(addr_stb),
    .bus_byte(bus_byte), .ecc_enable(ecc_enable), .op_fail_flag(op_fail_flag),
    .cache_rd_data(cache_rd_data), .dout_ready(dout_ready), .lun_ready_flag(lun_ready_flag),
    .array_ready_flag(array_ready_flag), .target_busy_n(target_busy_n),
    .out_status_mode(out_status_mode), .status_byte(status_byte),
    .cache_rd_addr(cache_rd_addr), .load_row(load_row), .array_load(array_load),
    .cache_copy(cache_copy), .prog_copy(prog_copy), .dout_valid(dout_valid),
    .dout_data(dout_data));

  nrcs_host_model i_host (.ref_clk(ref_clk), .stall_en(stall_en),
    .cache_rd_addr(cache_rd_addr), .cache_rd_data(cache_rd_data),
    .dout_valid(dout_valid), .dout_ready(dout_ready));

  // ************************************************
  // Helpers
  // ************************************************
  always @(posedge ref_clk)
  begin
    if (dout_valid === 1'b1 && dout_ready === 1'b1)
      got_q.push_back(dout_data);
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] mem_byte(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], 4'ha};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic settle;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic cmd(input logic [7:0] c);
    @(posedge ref_clk);
    cmd_stb <= 1'b1;
    bus_byte <= c;
    @(posedge ref_clk);
    cmd_stb <= 1'b0;
  endtask

  task automatic adr(input logic [7:0] b);
    @(posedge ref_clk);
    addr_stb <= 1'b1;
    bus_byte <= b;
    @(posedge ref_clk);
    addr_stb <= 1'b0;
  endtask

  task automatic addr5(input logic [11:0] c, input logic [16:0] r);
    adr(c[7:0]);
    adr({4'h0, c[11:8]});
    adr(r[7:0]);
    adr(r[15:8]);
    adr({7'h00, r[16]});
  endtask

  // Counts busy cycles from the edge it is called at until lun ready
  task automatic wait_busy(input int exp, input logic exp_arr);
    int n;
    n = 0;
    chk(target_busy_n, 1'b0);
    while (lun_ready_flag !== 1'b1 && n < 5000)
    begin
      n++;
      settle();
    end
    if (n >= 5000)
    begin
      n_fail++;
      close_out();
    end
    chk(n, exp);
    chk(array_ready_flag, exp_arr);
    chk(target_busy_n, 1'b1);
  endtask

  task automatic chk_stream(input logic [11:0] c, input int cnt);
    int w;
    w = 0;
    while (got_q.size() < cnt && w < 2000)
    begin
      w++;
      settle();
    end
    if (w >= 2000)
    begin
      n_fail++;
      close_out();
    end
    for (int i = 0; i < cnt; i++)
      chk(got_q[i], mem_byte(c + 12'(i)));
  endtask

  // ************************************************
  // Main sequence
  // ************************************************
  initial
  begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(status_byte, 8'h60);
    chk(target_busy_n, 1'b1);
    cmd(`NRCS_CMD_PAGE_CONF);
    settle();
    chk(lun_ready_flag, 1'b1);
    $display("Reset and lone confirm done");
    for (int e = 0; e < 2; e++)
    begin
      seed = lfsr(seed);
      col = {1'b0, seed[10:0]};
      row = seed[27:11];
      op_fail_flag <= seed[28];
      ecc_enable <= e[0];
      cmd(`NRCS_CMD_READ_MODE);
      addr5(col, row);
      cmd(`NRCS_CMD_PAGE_CONF);
      #1;
      got_q.delete();
      chk(array_load, 1'b1);
      chk(cache_rd_addr, col);
      chk(load_row, row);
      chk(status_byte, {7'h00, seed[28]});
      wait_busy(e ? 4080 : 4000, 1'b1);
      chk_stream(col, 6);
      seed = lfsr(seed);
      col = {1'b0, seed[10:0]};
      cmd(`NRCS_CMD_RND_READ);
      adr(col[7:0]);
      adr({4'h0, col[11:8]});
      cmd(`NRCS_CMD_RND_CONF);
      settle();
      got_q.delete();
      chk_stream(col, 6);
      cmd(`NRCS_CMD_STATUS);
      settle();
      chk(out_status_mode, 1'b1);
      chk(status_byte, {8'h60 | {7'h00, seed[29] & 1'b0} | {7'h00, op_fail_flag}});
      cmd(`NRCS_CMD_READ_MODE);
      settle();
      chk(out_status_mode, 1'b0);
      $display("Page read pass %0d done", e);
    end
    ecc_enable <= 1'b0;
    row = {seed[16:6], 6'h3f};
    cmd(`NRCS_CMD_READ_MODE);
    addr5(12'h000, row);
    cmd(`NRCS_CMD_PAGE_CONF);
    #1;
    wait_busy(4000, 1'b1);
    cmd(`NRCS_CMD_CACHE_SEQ);
    #1;
    got_q.delete();
    chk(cache_copy, 1'b1);
    chk(load_row, row + 17'h1);
    cmd(`NRCS_CMD_STATUS);
    cmd(`NRCS_CMD_READ_MODE);
    cmd(`NRCS_CMD_CACHE_LAST);
    settle();
    wait_busy(593, 1'b0);
    chk(out_status_mode, 1'b1);
    cmd(`NRCS_CMD_READ_MODE);
    chk_stream(12'h000, 4);
    cmd(`NRCS_CMD_PROG);
    settle();
    chk(lun_ready_flag, 1'b1);
    chk(array_ready_flag, 1'b0);
    seed = lfsr(seed);
    row[5:0] = seed[5:0];
    cmd(`NRCS_CMD_READ_MODE);
    addr5({1'b0, seed[16:6]}, row);
    cmd(`NRCS_CMD_CACHE_SEQ);
    #1;
    got_q.delete();
    chk(load_row, row);
    chk(array_load, 1'b1);
    wait_busy(600, 1'b0);
    chk_stream(12'h000, 4);
    cmd(`NRCS_CMD_CACHE_LAST);
    #1;
    got_q.delete();
    chk(cache_copy, 1'b1);
    chk(array_load, 1'b0);
    wait_busy(600, 1'b1);
    chk_stream(12'h000, 4);
    $display("Cache read sequence done");
    cmd(`NRCS_CMD_PROG);
    addr5(12'h000, {seed[27:17], 6'h00});
    cmd(`NRCS_CMD_PCACHE_CONF);
    #1;
    chk(prog_copy, 1'b1);
    wait_busy(600, 1'b0);
    cmd(`NRCS_CMD_CACHE_SEQ);
    #1;
    chk(array_load, 1'b0);
    chk(lun_ready_flag, 1'b1);
    cmd(`NRCS_CMD_PROG);
    addr5(12'h000, {seed[27:17], 6'h01});
    cmd(`NRCS_CMD_PROG_CONF);
    #1;
    chk(prog_copy, 1'b1);
    wait_busy(4000, 1'b1);
    $display("Program cache sequence done");
    rst_n <= 1'b0;
    settle();
    chk(lun_ready_flag, 1'b1);
    chk(out_status_mode, 1'b1);
    $display("Second reset done");
    close_out();
  end
endmodule
